// File: mppi_top.sv
// MAC side of the PHY pin interface: transmit lanes, management port,
// PHY reset, strap capture, wake and interrupt pins, register port.
// Assumes all pin inputs are asynchronous to clk and link clocks run
// well below clk/4 so that their edges are found by sampling.
`timescale 1ns/1ns
module mppi_top import mppi_pkg::*; #(
  parameter int unsigned PHY_HOLD_CYCLES = PHY_HOLD_CYC,
  parameter int unsigned MDC_HALF        = MDC_HALF_CYC
) (
  input  wire logic              clk,
  input  wire logic              resetn,
  input  wire logic [ADDR_W-1:0] reg_addr,
  input  wire logic [DATA_W-1:0] reg_wdata,
  input  wire logic              reg_wr,
  input  wire logic              reg_rd,
  output logic      [DATA_W-1:0] reg_rdata,
  input  wire logic              tx_valid,
  input  wire logic [3:0]        tx_nibble,
  output logic                   tx_ready,
  input  wire logic              wake_pattern_evt,
  input  wire logic              sample_frame_evt,
  input  wire logic              rmii_mode_in,
  input  wire logic              mii_tx_clk,
  input  wire logic              rmii_ref_clk,
  input  wire logic              mii_rx_clk,
  input  wire logic              rx_dv_in,
  input  wire logic              rx_er_in,
  input  wire logic              link_status1,
  input  wire logic              link_status2,
  input  wire logic              aux_power_present_strap,
  input  wire logic              power_on_reset_in_n,
  output logic                   tx_en,
  output logic [3:0]             txd,
  output logic                   mdc,
  input  wire logic              mdio_i,
  output logic                   mdio_o,
  output logic                   mdio_oe,
  output logic                   phoneline_phy_tristate,
  output logic                   phy_reset_out_n,
  output logic                   wake_on_lan_out,
  output logic                   pme_n_o,
  output logic                   pme_n_oe,
  output logic                   irq_n_o,
  output logic                   irq_n_oe,
  output logic                   irq
);
  localparam int unsigned HW = $clog2(PHY_HOLD_CYCLES + 1);

  logic [NSYNC-1:0]  pin_s;
  logic              rmii_s;
  logic              por_s;
  logic              por_q;
  logic              por_rise;
  logic              lclk_s;
  logic              lclk_q;
  logic              lrise;
  logic              rclk_s;
  logic              rclk_q;
  logic              rrise;
  logic              half_q;
  logic [1:0]        hold_q;
  logic [HW-1:0]     hold_cnt_q;
  logic              ctrl_prst_q;
  logic              aux_q;
  logic [1:0]        link_q;
  logic              link_vld_q;
  logic [NEV-1:0]    ev;
  logic [NEV-1:0]    int_stat_q;
  logic [NEV-1:0]    int_en_q;
  logic [NEV-1:0]    int_clr;
  logic              wr_ctrl;
  logic              mdio_start;
  logic              mdio_busy;
  logic              mdio_done;
  logic [15:0]       mdio_rdata;
  logic [DATA_W-1:0] rd_mux;
  mppi_mdio_cmd_type mdio_cmd;

  mppi_sync #(
    .WIDTH (NSYNC)
  ) u_sync (
    .clk (clk),
    .d   ({mdio_i, power_on_reset_in_n, aux_power_present_strap, rmii_mode_in,
           link_status2, link_status1, rx_er_in, rx_dv_in, mii_rx_clk, rmii_ref_clk,
           mii_tx_clk}),
    .q   (pin_s)
  );

  assign rmii_s = pin_s[SY_RMII];
  assign por_s  = pin_s[SY_POR];

  // Link clocks: reduced mode times both directions from the reference clock
  assign lclk_s = rmii_s ? pin_s[SY_REF] : pin_s[SY_TXCLK];
  assign rclk_s = rmii_s ? pin_s[SY_REF] : pin_s[SY_RXCLK];

  // No reset here, so no false link edge follows the release of reset
  always_ff @(posedge clk) begin
    lclk_q <= lclk_s;
    rclk_q <= rclk_s;
  end

  assign lrise = lclk_s && !lclk_q;
  assign rrise = rclk_s && !rclk_q;

  // Register port decode
  assign wr_ctrl    = reg_wr && (reg_addr == REG_CTRL);
  assign mdio_start = reg_wr && (reg_addr == REG_MDIO_CMD) && !mdio_busy;
  assign int_clr    = (reg_wr && reg_addr == REG_INT_CLR) ? reg_wdata[NEV-1:0] : '0;
  assign mdio_cmd   = '{read:  reg_wdata[CMD_READ_BIT],
                        phy:   reg_wdata[CMD_PHY_LSB +: 5],
                        regad: reg_wdata[CMD_REG_LSB +: 5],
                        wdata: reg_wdata[15:0]};

  always_ff @(posedge clk) begin
    if (!resetn) begin
      phoneline_phy_tristate <= 1'b0;
      ctrl_prst_q            <= 1'b0;
    end else if (wr_ctrl) begin
      phoneline_phy_tristate <= reg_wdata[CTRL_TRISTATE];
      ctrl_prst_q            <= reg_wdata[CTRL_PHY_RST];
    end
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      int_en_q <= '0;
    end else if (reg_wr && reg_addr == REG_INT_EN) begin
      int_en_q <= reg_wdata[NEV-1:0];
    end
  end

  always_comb begin
    rd_mux = '0;
    case (reg_addr)
      REG_CTRL: begin
        rd_mux[CTRL_TRISTATE] = phoneline_phy_tristate;
        rd_mux[CTRL_PHY_RST]  = ctrl_prst_q;
      end
      REG_MDIO_STAT: begin
        rd_mux[15:0]          = mdio_rdata;
        rd_mux[STAT_BUSY_BIT] = mdio_busy;
      end
      REG_INT_STAT: rd_mux[NEV-1:0] = int_stat_q;
      REG_INT_EN:   rd_mux[NEV-1:0] = int_en_q;
      REG_STATUS: begin
        rd_mux[ST_AUX]  = aux_q;
        rd_mux[ST_RMII] = rmii_s;
        rd_mux[ST_WOL]  = wake_on_lan_out;
        rd_mux[ST_PRST] = !phy_reset_out_n;
        rd_mux[ST_LNK1] = pin_s[SY_LNK1];
        rd_mux[ST_LNK2] = pin_s[SY_LNK2];
      end
      default: rd_mux = '0;
    endcase
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      reg_rdata <= '0;
    end else begin
      reg_rdata <= reg_rd ? rd_mux : '0;
    end
  end

  // Transmit lanes change just after a link clock rise, so they are
  // stable at the following falling edge where the PHY latches them
  assign tx_ready = lrise && (!rmii_s || !half_q);

  always_ff @(posedge clk) begin
    if (!resetn) begin
      tx_en  <= 1'b0;
      txd    <= '0;
      half_q <= 1'b0;
      hold_q <= '0;
    end else if (lrise) begin
      if (rmii_s && half_q) begin
        txd    <= {2'h0, hold_q};
        half_q <= 1'b0;
      end else if (tx_valid) begin
        tx_en  <= 1'b1;
        txd    <= rmii_s ? {2'h0, tx_nibble[1:0]} : tx_nibble;
        hold_q <= tx_nibble[3:2];
        half_q <= rmii_s;
      end else begin
        tx_en <= 1'b0;
        txd   <= '0;
      end
    end
  end

  // PHY reset and strap capture
  assign por_rise = por_s && !por_q;

  always_ff @(posedge clk) begin
    if (!resetn) begin
      por_q <= 1'b0;
    end else begin
      por_q <= por_s;
    end
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      hold_cnt_q <= '0;
    end else if (!por_s) begin
      hold_cnt_q <= HW'(PHY_HOLD_CYCLES);
    end else if (hold_cnt_q != '0) begin
      hold_cnt_q <= hold_cnt_q - HW'(1);
    end
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      phy_reset_out_n <= 1'b0;
    end else begin
      phy_reset_out_n <= por_s && (hold_cnt_q == '0) && !ctrl_prst_q;
    end
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      aux_q <= 1'b0;
    end else if (por_rise) begin
      aux_q <= pin_s[SY_STRAP];
    end
  end

  // Events
  always_ff @(posedge clk) begin
    if (!resetn) begin
      link_q     <= '0;
      link_vld_q <= 1'b0;
    end else begin
      link_q     <= {pin_s[SY_LNK2], pin_s[SY_LNK1]};
      link_vld_q <= 1'b1;
    end
  end

  always_comb begin
    ev            = '0;
    ev[EV_MDIO]   = mdio_done;
    ev[EV_RXERR]  = rrise && pin_s[SY_DV] && pin_s[SY_ER];
    ev[EV_LINK]   = link_vld_q && (link_q != {pin_s[SY_LNK2], pin_s[SY_LNK1]});
    ev[EV_WAKE]   = wake_pattern_evt;
    ev[EV_SAMPLE] = sample_frame_evt;
  end

  // A new event wins over a clear in the same cycle
  always_ff @(posedge clk) begin
    if (!resetn) begin
      int_stat_q <= '0;
    end else begin
      int_stat_q <= (int_stat_q & ~int_clr) | ev;
    end
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      wake_on_lan_out <= 1'b0;
    end else if (ev[EV_LINK] || ev[EV_WAKE] || ev[EV_SAMPLE]) begin
      wake_on_lan_out <= 1'b1;
    end else if (wr_ctrl && reg_wdata[CTRL_WOL_CLR]) begin
      wake_on_lan_out <= 1'b0;
    end
  end

  assign pme_n_o  = 1'b0;
  assign pme_n_oe = wake_on_lan_out;
  assign irq      = |(int_stat_q & int_en_q);
  assign irq_n_o  = 1'b0;
  assign irq_n_oe = irq;

  mppi_mdio #(
    .HALF_CYC (MDC_HALF)
  ) u_mdio (
    .clk     (clk),
    .resetn  (resetn),
    .start   (mdio_start),
    .cmd     (mdio_cmd),
    .busy    (mdio_busy),
    .done    (mdio_done),
    .rdata   (mdio_rdata),
    .mdc     (mdc),
    .mdio_o  (mdio_o),
    .mdio_oe (mdio_oe),
    .mdio_i  (pin_s[SY_MDIO])
  );

  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);

  property p_irq_level;
    |(int_stat_q & int_en_q) |-> irq_n_oe && !irq_n_o;
  endproperty
  a_irq_level: assert property (p_irq_level) else $error("interrupt not pulled");
  property p_irq_release;
    int_stat_q == '0 |-> !irq_n_oe;
  endproperty
  a_irq_release: assert property (p_irq_release) else $error("interrupt held idle");
  property p_txen_rise;
    $rose(tx_en) |-> $past(lrise) && $past(tx_valid);
  endproperty
  a_txen_rise: assert property (p_txen_rise) else $error("enable without data");
  property p_rmii_upper;
    rmii_s && $past(rmii_s) && $past(lrise) |-> txd[3:2] == 2'h0;
  endproperty
  a_rmii_upper: assert property (p_rmii_upper) else $error("upper lanes in reduced");
  property p_rx_er_ignored;
    !pin_s[SY_DV] |-> !ev[EV_RXERR];
  endproperty
  a_rx_er_ignored: assert property (p_rx_er_ignored) else $error("error without valid");
  property p_por_follow;
    !por_s |=> !phy_reset_out_n;
  endproperty
  a_por_follow: assert property (p_por_follow) else $error("PHY reset not following");
  property p_phy_hold;
    $rose(por_s) |=> !phy_reset_out_n [*8];
  endproperty
  a_phy_hold: assert property (p_phy_hold) else $error("PHY reset released early");
  property p_strap;
    resetn && por_rise |=> aux_q == $past(pin_s[SY_STRAP]);
  endproperty
  a_strap: assert property (p_strap) else $error("strap not captured");
  property p_wol;
    wake_pattern_evt || sample_frame_evt |=> wake_on_lan_out;
  endproperty
  a_wol: assert property (p_wol) else $error("wake output missed");
  property p_pme;
    wake_on_lan_out |-> pme_n_oe && !pme_n_o;
  endproperty
  a_pme: assert property (p_pme) else $error("wake request not pulled");
  property p_tristate;
    wr_ctrl |=> phoneline_phy_tristate == $past(reg_wdata[CTRL_TRISTATE]);
  endproperty
  a_tristate: assert property (p_tristate) else $error("tristate not written");
  property p_mode_pace;
    rmii_s && half_q |-> !tx_ready;
  endproperty
  a_mode_pace: assert property (p_mode_pace) else $error("nibble taken mid dibit");

  c_rmii_tx: cover property (rmii_s && tx_en && half_q);
  c_mii_tx: cover property (!rmii_s && tx_en);
  c_wol_set: cover property ($rose(wake_on_lan_out));
  c_irq: cover property ($rose(irq));
endmodule

// File: mppi_pkg.sv
// Constants, register map and carrier types of the MAC-to-PHY pin interface.
// Assumes a 100 MHz system clock; the MDC half period and PHY hold cycle counts are derived from it here.
package mppi_pkg;
  localparam int unsigned CLK_HZ        = 100_000_000;
  localparam int unsigned CLK_PERIOD_NS = 10;
  localparam int unsigned MDC_MAX_HZ    = 2_500_000;
  localparam int unsigned MDC_HALF_CYC  = (CLK_HZ + 2 * MDC_MAX_HZ - 1) / (2 * MDC_MAX_HZ);
  localparam int unsigned PHY_HOLD_NS   = 1_300_000;
  localparam int unsigned PHY_HOLD_CYC  = (PHY_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  localparam int unsigned ADDR_W = 8;
  localparam int unsigned DATA_W = 32;
  localparam logic [7:0] REG_CTRL      = 8'h00;
  localparam logic [7:0] REG_MDIO_CMD  = 8'h04;
  localparam logic [7:0] REG_MDIO_STAT = 8'h08;
  localparam logic [7:0] REG_INT_STAT  = 8'h0C;
  localparam logic [7:0] REG_INT_CLR   = 8'h10;
  localparam logic [7:0] REG_INT_EN    = 8'h14;
  localparam logic [7:0] REG_STATUS    = 8'h18;

  localparam int unsigned CTRL_TRISTATE = 0;
  localparam int unsigned CTRL_PHY_RST  = 1;
  localparam int unsigned CTRL_WOL_CLR  = 2;
  localparam int unsigned CMD_REG_LSB   = 16;
  localparam int unsigned CMD_PHY_LSB   = 21;
  localparam int unsigned CMD_READ_BIT  = 26;
  localparam int unsigned STAT_BUSY_BIT = 16;
  localparam int unsigned ST_AUX  = 0;
  localparam int unsigned ST_RMII = 1;
  localparam int unsigned ST_WOL  = 2;
  localparam int unsigned ST_PRST = 3;
  localparam int unsigned ST_LNK1 = 4;
  localparam int unsigned ST_LNK2 = 5;

  localparam int unsigned NEV       = 5;
  localparam int unsigned EV_MDIO   = 0;
  localparam int unsigned EV_RXERR  = 1;
  localparam int unsigned EV_LINK   = 2;
  localparam int unsigned EV_WAKE   = 3;
  localparam int unsigned EV_SAMPLE = 4;

  localparam int unsigned MDIO_PRE_BITS   = 32;
  localparam int unsigned MDIO_HDR_BITS   = 46;
  localparam int unsigned MDIO_DATA_BITS  = 48;
  localparam int unsigned MDIO_FRAME_BITS = 64;
  localparam logic [1:0]  MDIO_START = 2'h1;
  localparam logic [1:0]  MDIO_OP_RD = 2'h2;
  localparam logic [1:0]  MDIO_OP_WR = 2'h1;
  localparam logic [1:0]  MDIO_TA_WR = 2'h2;

  localparam int unsigned NSYNC = 11;
  localparam int unsigned SY_TXCLK = 0;
  localparam int unsigned SY_REF   = 1;
  localparam int unsigned SY_RXCLK = 2;
  localparam int unsigned SY_DV    = 3;
  localparam int unsigned SY_ER    = 4;
  localparam int unsigned SY_LNK1  = 5;
  localparam int unsigned SY_LNK2  = 6;
  localparam int unsigned SY_RMII  = 7;
  localparam int unsigned SY_STRAP = 8;
  localparam int unsigned SY_POR   = 9;
  localparam int unsigned SY_MDIO  = 10;

  typedef struct packed {
    logic        read;
    logic [4:0]  phy;
    logic [4:0]  regad;
    logic [15:0] wdata;
  } mppi_mdio_cmd_type;
endpackage

// File: mppi_sync.sv
// Two-flop synchroniser for a group of asynchronous pins.
// Assumes each bit is an independent level; no bus coherence.
`timescale 1ns/1ns
module mppi_sync #(
  parameter int unsigned WIDTH = 1
) (
  input  wire logic             clk,
  input  wire logic [WIDTH-1:0] d,
  output logic      [WIDTH-1:0] q
);
  logic [WIDTH-1:0] meta_q;

  always_ff @(posedge clk) begin
    meta_q <= d;
    q      <= meta_q;
  end
endmodule

// File: mppi_mdio.sv
// Management frame engine: clock divider, frame shifter, line direction control.
// Assumes mdio_i is already synchronised to clk.
`timescale 1ns/1ns
module mppi_mdio import mppi_pkg::*; #(
  parameter int unsigned HALF_CYC = MDC_HALF_CYC
) (
  input  wire logic              clk,
  input  wire logic              resetn,
  input  wire logic              start,
  input  wire mppi_mdio_cmd_type cmd,
  output logic                   busy,
  output logic                   done,
  output logic [15:0]            rdata,
  output logic                   mdc,
  output logic                   mdio_o,
  output logic                   mdio_oe,
  input  wire logic              mdio_i
);
  localparam int unsigned DW = $clog2(HALF_CYC + 1);
  typedef enum logic {MPPI_IDLE, MPPI_RUN} mppi_mst_type;

  mppi_mst_type state_q;
  logic [DW-1:0] div_q;
  logic [6:0]    bit_q;
  logic [31:0]   frame_q;
  logic          read_q;
  logic          tick;
  logic          last_bit;

  assign tick     = (div_q == DW'(HALF_CYC - 1));
  assign last_bit = (bit_q == 7'(MDIO_FRAME_BITS - 1));
  assign busy     = (state_q == MPPI_RUN);

  always_ff @(posedge clk) begin
    if (!resetn || !busy || tick) begin
      div_q <= '0;
    end else begin
      div_q <= div_q + DW'(1);
    end
  end

  always_ff @(posedge clk) begin
    if (!resetn || !busy) begin
      mdc <= 1'b0;
    end else if (tick) begin
      mdc <= ~mdc;
    end
  end

  always_ff @(posedge clk) begin
    done <= 1'b0;
    if (!resetn) begin
      state_q <= MPPI_IDLE;
      bit_q   <= '0;
      frame_q <= '0;
      read_q  <= 1'b0;
    end else begin
      case (state_q)
        MPPI_IDLE: begin
          if (start) begin
            state_q <= MPPI_RUN;
            bit_q   <= '0;
            read_q  <= cmd.read;
            frame_q <= {MDIO_START, cmd.read ? MDIO_OP_RD : MDIO_OP_WR, cmd.phy, cmd.regad,
                        MDIO_TA_WR, cmd.wdata};
          end
        end
        MPPI_RUN: begin
          if (tick && mdc) begin
            if (last_bit) begin
              state_q <= MPPI_IDLE;
              done    <= 1'b1;
            end else begin
              bit_q <= bit_q + 7'(1);
            end
            if (bit_q >= 7'(MDIO_PRE_BITS)) begin
              frame_q <= {frame_q[30:0], 1'b0};
            end
          end
        end
        default: state_q <= MPPI_IDLE;
      endcase
    end
  end

  // Read data sampled as the clock rises, while the PHY owns the line
  always_ff @(posedge clk) begin
    if (!resetn) begin
      rdata <= '0;
    end else if (busy && tick && !mdc && read_q && bit_q >= 7'(MDIO_DATA_BITS)) begin
      rdata <= {rdata[14:0], mdio_i};
    end
  end

  assign mdio_o  = busy && ((bit_q < 7'(MDIO_PRE_BITS)) || frame_q[31]);
  assign mdio_oe = busy && (!read_q || bit_q < 7'(MDIO_HDR_BITS));

  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);

  property p_mdc_half;
    $changed(mdc) |=> $stable(mdc) [*8];
  endproperty
  a_mdc_half: assert property (p_mdc_half) else $error("mdc half period too short");
  property p_hdr_drive;
    busy && bit_q < 7'(MDIO_HDR_BITS) |-> mdio_oe;
  endproperty
  a_hdr_drive: assert property (p_hdr_drive) else $error("header not driven");
  property p_rd_release;
    busy && read_q && bit_q >= 7'(MDIO_HDR_BITS) |-> !mdio_oe;
  endproperty
  a_rd_release: assert property (p_rd_release) else $error("line held in read data");
  property p_preamble;
    busy && bit_q < 7'(MDIO_PRE_BITS) |-> mdio_o;
  endproperty
  a_preamble: assert property (p_preamble) else $error("preamble bit not one");
  c_mdio_read: cover property (done && read_q);
endmodule

// File: mppi_phy_model.sv
// Far-side PHY model: link clocks and the PHY end of the management line.
// Assumes the device releases the line for the data half of a read.
`timescale 1ns/1ns
module mppi_phy_model #(
  parameter logic [15:0] RD_DATA = 16'hC3A5
) (
  input  wire logic mdc,
  input  wire logic mdio_o,
  input  wire logic mdio_oe,
  input  wire logic phoneline_phy_tristate,
  output logic      mdio_i,
  output logic      mii_tx_clk,
  output logic      rmii_ref_clk,
  output logic      mii_rx_clk
);
  int   k   = 0;
  logic drv = 1'b0;
  logic val = 1'b1;

  // Continuous clocks at the bench link rate, off the system clock phase
  initial begin
    mii_tx_clk = 1'b0;
    #3;
    forever #80 mii_tx_clk = ~mii_tx_clk;
  end
  assign rmii_ref_clk = mii_tx_clk;
  initial begin
    mii_rx_clk = 1'b0;
    #41;
    forever #80 mii_rx_clk = ~mii_rx_clk;
  end

  // Released line counts bit slots; PHY drives TA low then data MSB first
  always @(negedge mdio_oe) k = 0;
  always @(negedge mdc) begin
    #1;
    if (!mdio_oe)
      k = k + 1;
    drv = !mdio_oe && !phoneline_phy_tristate && k >= 2 && k <= 18;
    val = (k == 2) ? 1'b0 : RD_DATA[4'(18 - k)];
  end
  // Pull-up holds the line high whenever nobody drives it
  assign mdio_i = mdio_oe ? mdio_o : (drv ? val : 1'b1);
endmodule

// File: mppi_top_tb.sv
// Self-checking bench of the PHY pin interface: registers, management
// frames, transmit lanes, events. Assumes mppi_phy_model on the far side.
`timescale 1ns/1ns
module mppi_top_tb import mppi_pkg::*;;
  localparam int HOLD = 50;
  localparam int HALF = MDC_HALF_CYC;
  typedef struct {logic [7:0] a; logic [31:0] d; logic [31:0] e;} mppi_row_type;
  mppi_row_type rows[5] = '{'{REG_CTRL, 32'h7, 32'h3}, '{REG_CTRL, 32'h0, 32'h0},
    '{REG_INT_EN, 32'h1F, 32'h1F}, '{8'h40, 32'hFFFFFFFF, 32'h0},
    '{REG_INT_STAT, 32'h1F, 32'h0}};
  logic        clk, resetn = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0, tx_valid = 1'b0;
  logic [7:0]  reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h0, reg_rdata, d;
  logic [3:0]  tx_nibble = 4'h0, txd;
  logic        wake_pattern_evt = 1'b0, sample_frame_evt = 1'b0, rmii_mode_in = 1'b0;
  logic        rx_dv_in = 1'b0, rx_er_in = 1'b0, link_status1 = 1'b0, link_status2 = 1'b0;
  logic        aux_power_present_strap = 1'b1, power_on_reset_in_n = 1'b1;
  logic        tx_ready, mii_tx_clk, rmii_ref_clk, mii_rx_clk, tx_en, mdc, mdio_i, mdio_o;
  logic        mdio_oe, phoneline_phy_tristate, phy_reset_out_n, wake_on_lan_out;
  logic        pme_n_o, pme_n_oe, irq_n_o, irq_n_oe, irq;
  logic [63:0] ln, oe;
  int          error_cnt = 0, check_count = 0, n;

  mppi_top #(.PHY_HOLD_CYCLES(HOLD), .MDC_HALF(HALF)) u_dut (.*);
  mppi_phy_model u_phy (.*);

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  task automatic chk(input string nm, input logic [63:0] e, input logic [63:0] g);
    check_count++;
    if (g !== e) begin
      error_cnt++;
      $display("unexpected %s: expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= v;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] v);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 v = reg_rdata;
  endtask

  // One management frame, line and drive captured at each clock rise
  task automatic frame(input logic rdop);
    time t0;
    wr(REG_MDIO_CMD, {5'h0, rdop, 5'h0B, 5'h03, 16'h9C35});
    for (int i = 0; i < 64; i++) begin
      t0 = $time;
      @(posedge mdc);
      ln[63 - i] = mdio_i;
      oe[63 - i] = mdio_oe;
    end
    chk("mdc period", 1_000_000_000 / MDC_MAX_HZ, $time - t0);
    repeat (HALF + 4) @(posedge clk);
    #1 chk("irq pins", 3'b110, {irq, irq_n_oe, irq_n_o});
    rd(REG_INT_STAT, d);
    chk("frame done", 32'h1, d);
    wr(REG_INT_CLR, 32'h1);
    #1 chk("irq cleared", 1'b0, irq);
  endtask

  task automatic tx(input logic rm, input logic [3:0] nb, input logic [3:0] nx);
    int w;
    w = 0;
    do begin
      @(negedge clk);
      w++;
    end while (tx_ready !== 1'b1 && w < 100);
    chk("tx ready", 1'b1, tx_ready);
    @(posedge clk);
    tx_nibble <= nx;
    repeat (8) @(posedge clk);
    #1 chk("lanes", {1'b1, rm ? {2'b00, nb[1:0]} : nb}, {tx_en, txd});
    if (rm) begin
      repeat (16) @(posedge clk);
      #1 chk("upper dibit", {3'b100, nb[3:2]}, {tx_en, txd});
    end
  endtask

  task automatic tx_stop;
    @(posedge clk);
    tx_valid <= 1'b0;
    repeat (40) @(posedge clk);
    #1 chk("tx idle", 1'b0, tx_en);
  endtask

  task automatic wrap_up;
    $display("checks %0d mismatches %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  initial begin
    #500_000;
    error_cnt++;
    $display("unexpected watchdog expiry");
    wrap_up;
  end

  initial begin
    repeat (9) @(posedge clk);
    #1 chk("reset outputs", 0, {tx_en, mdc, mdio_oe, wake_on_lan_out, irq, phy_reset_out_n});
    @(posedge clk);
    resetn <= 1'b1;
    rd(REG_STATUS, d);
    chk("strap and mode", 32'h1, d & 32'h3);
    foreach (rows[i]) begin
      wr(rows[i].a, rows[i].d);
      rd(rows[i].a, d);
      chk("register", rows[i].e, d);
      chk("tristate pin", rows[i].a == REG_CTRL && rows[i].e[0], phoneline_phy_tristate);
    end
    frame(1'b0);
    chk("write frame", {32'hFFFFFFFF, MDIO_START, MDIO_OP_WR, 10'h163, MDIO_TA_WR, 16'h9C35}, ln);
    chk("write drive", '1, oe);
    frame(1'b1);
    chk("read frame", {32'hFFFFFFFF, MDIO_START, MDIO_OP_RD, 10'h163, 2'b10, 16'hC3A5}, ln);
    chk("read drive", {{46{1'b1}}, 18'h0}, oe);
    rd(REG_MDIO_STAT, d);
    chk("read data", 32'h0000C3A5, d);
    @(posedge clk);
    tx_nibble <= 4'hA;
    tx_valid <= 1'b1;
    tx(1'b0, 4'hA, 4'h5);
    tx(1'b0, 4'h5, 4'h3);
    tx_stop;
    @(posedge clk);
    rmii_mode_in <= 1'b1;
    repeat (10) @(posedge clk);
    rd(REG_STATUS, d);
    chk("reduced mode", 1'b1, d[ST_RMII]);
    @(posedge clk);
    tx_nibble <= 4'h9;
    tx_valid <= 1'b1;
    tx(1'b1, 4'h9, 4'h6);
    tx(1'b1, 4'h6, 4'h6);
    tx_stop;
    for (int e = 0; e < 4; e++) begin
      wr(REG_CTRL, 32'h4);
      wr(REG_INT_CLR, 32'h1F);
      #1 chk("wake idle", 1'b0, wake_on_lan_out);
      @(posedge clk);
      case (e)
        0: wake_pattern_evt <= 1'b1;
        1: sample_frame_evt <= 1'b1;
        2: link_status1 <= ~link_status1;
        default: link_status2 <= ~link_status2;
      endcase
      @(posedge clk);
      wake_pattern_evt <= 1'b0;
      sample_frame_evt <= 1'b0;
      repeat (6) @(posedge clk);
      #1 chk("wake and pme", 3'b101, {wake_on_lan_out, pme_n_o, pme_n_oe});
      rd(REG_INT_STAT, d);
      chk("event", 32'h1 << (e > 1 ? EV_LINK : e == 0 ? EV_WAKE : EV_SAMPLE), d);
    end
    wr(REG_INT_CLR, 32'h1F);
    rx_er_in <= 1'b1;
    repeat (60) @(posedge clk);
    rd(REG_INT_STAT, d);
    chk("error without valid", 32'h0, d);
    @(posedge clk);
    rx_dv_in <= 1'b1;
    repeat (60) @(posedge clk);
    rd(REG_INT_STAT, d);
    chk("error with valid", 32'h1 << EV_RXERR, d);
    @(posedge clk);
    power_on_reset_in_n <= 1'b0;
    aux_power_present_strap <= 1'b0;
    repeat (6) @(posedge clk);
    #1 chk("phy reset follows", 1'b0, phy_reset_out_n);
    @(posedge clk);
    power_on_reset_in_n <= 1'b1;
    n = 0;
    while (phy_reset_out_n !== 1'b1 && n < 200) begin
      @(negedge clk);
      n++;
    end
    chk("phy reset hold", 1'b1, n >= HOLD && n <= HOLD + 6);
    rd(REG_STATUS, d);
    chk("strap latched", 1'b0, d[ST_AUX]);
    // Reset again in mid-run: wake output clears, strap is taken afresh
    @(posedge clk);
    resetn <= 1'b0;
    repeat (3) @(posedge clk);
    #1 chk("reset again", 0, {tx_en, mdc, wake_on_lan_out, irq, phy_reset_out_n});
    @(posedge clk);
    resetn <= 1'b1;
    rd(REG_STATUS, d);
    chk("strap after reset", 32'h2, d & 32'h3);
    wrap_up;
  end
endmodule
